// File: logic/mmc_pkg.sv
// package for the modem mode control block: register map, fields, reset values
// What this block does
// - cold reset output active while bit is 0
// - warm reset bit forces frame sync high
// - select 00: line2 other uart, line3 ours
// - select 01: line2 receive, line3 transmit
// - select 11: line2 from our combined interrupt
// - both lines: tx empty, rx full sources
// - mode bit 6 clear: rx not-empty instead
// - each channel has own interrupt line
// - slot delay bit delays first slot one bit
// - shift direction: 0 msb first, 1 lsb
// - hard reset selects uart mode 00
// - writing uart mode from modem resets channel
// - return to uart mode empties both fifos
package mmc_pkg;
    localparam logic [3:0] MMC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] MMC_ADDR_STATUS = 4'h4;
    localparam logic [7:0] MMC_CONTROL_RESET = 8'h00;
    localparam int MMC_BIT_COLD_RESET_N = 7;
    localparam int MMC_BIT_WARM_RESET = 6;
    localparam int MMC_POS_DMA_SELECT = 4;
    localparam int MMC_BIT_SLOT_DELAY = 3;
    localparam int MMC_BIT_SHIFT_DIR = 2;
    localparam int MMC_POS_MODE = 0;
    localparam int MMC_RESET_PULSE_CYCLES = 1;

    typedef enum logic [1:0] {
        MMC_MODE_UART,
        MMC_MODE_CODEC8,
        MMC_MODE_CODEC16,
        MMC_MODE_AC97
    } mmc_mode_e;

    typedef struct packed {
        logic coldResetN;
        logic warmReset;
        logic [1:0] dmaSelect;
        logic slotDelay;
        logic shiftDir;
        logic [1:0] mode;
    } mmc_control_s;

    typedef struct packed {
        logic txRxIrq;
        logic rxIrq;
        logic txIrq;
        logic rxFull;
        logic rxNotEmpty;
        logic txEmpty;
    } mmc_events_s;
endpackage

// File: logic/mmc_dma_route.sv
// request line routing for the two dma lines and the interrupt lines
module mmc_dma_route (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // selection
    input wire logic [1:0] dmaSelect,
    input wire logic rxFullMode,
    // event sources
    input wire logic otherIrq,
    input wire mmc_pkg::mmc_events_s ev,
    // request outputs
    output logic dmaReq2,
    output logic dmaReq3,
    output logic irqOwn,
    output logic irqOther
);
    logic rxCond;

    // rx interrupt condition follows mode register one bit 6
    assign rxCond = rxFullMode ? ev.rxFull : ev.rxNotEmpty;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dmaReq2 <= 1'b0;
            dmaReq3 <= 1'b0;
        end else begin
            case (dmaSelect)
                2'h1: begin
                    dmaReq2 <= rxCond;
                    dmaReq3 <= ev.txEmpty;
                end
                2'h3: begin
                    dmaReq2 <= ev.txRxIrq;
                    dmaReq3 <= 1'b0;
                end
                default: begin
                    // 00 and 10 share one route
                    dmaReq2 <= otherIrq;
                    dmaReq3 <= ev.txRxIrq;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqOwn <= 1'b0;
            irqOther <= 1'b0;
        end else begin
            irqOwn <= ev.txRxIrq;
            irqOther <= otherIrq;
        end
    end
endmodule // mmc_dma_route

// File: logic/mmc_modem_ctrl.sv
// modem mode control register with avalon-mm slave and channel controls
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
module mmc_modem_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // channel events, same clock
    input wire logic otherIrq,
    input wire mmc_pkg::mmc_events_s ev,
    input wire logic rxFullMode,
    input wire logic frameSyncIn,
    // channel controls
    output mmc_pkg::mmc_control_s control,
    output logic coldResetOut_n,
    output logic frameSyncOut,
    output logic msbFirst,
    output logic slotDelayBits,
    output logic [1:0] modeSel,
    output logic channelReset,
    output logic fifoFlush,
    // request lines
    output logic dmaReq2,
    output logic dmaReq3,
    output logic irqOwn,
    output logic irqOther
);
    mmc_pkg::mmc_control_s control_reg;
    mmc_pkg::mmc_control_s control_next;
    logic accessDone_reg;
    logic writeHit;
    logic backToUart;

    // one wait cycle per access keeps read data registered
    assign writeHit = write && accessDone_reg && address == mmc_pkg::MMC_ADDR_CONTROL && byteenable[0];
    assign backToUart = writeHit && control_reg.mode != 2'(mmc_pkg::MMC_MODE_UART)
        && writedata[mmc_pkg::MMC_POS_MODE +: 2] == 2'(mmc_pkg::MMC_MODE_UART);

    always_comb begin
        control_next = control_reg;
        if (backToUart) begin
            // whole channel restarts, this register included
            control_next = mmc_pkg::MMC_CONTROL_RESET;
        end else if (writeHit) begin
            control_next = writedata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            accessDone_reg <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            accessDone_reg <= (read || write) && !accessDone_reg;
            waitrequest <= !((read || write) && !accessDone_reg);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg <= mmc_pkg::MMC_CONTROL_RESET;
        end else begin
            control_reg <= control_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0;
        end else if (read && !accessDone_reg) begin
            case (address)
                mmc_pkg::MMC_ADDR_CONTROL: readdata <= {24'h0, control_reg};
                mmc_pkg::MMC_ADDR_STATUS: readdata <= {26'h0, ev};
                default: readdata <= 32'h0;
            endcase
        end
    end

    // channel reset pulse also clears fifo pointers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            channelReset <= 1'b0;
            fifoFlush <= 1'b0;
        end else begin
            channelReset <= backToUart;
            fifoFlush <= backToUart;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            control <= mmc_pkg::MMC_CONTROL_RESET;
            coldResetOut_n <= 1'b0;
            frameSyncOut <= 1'b0;
            msbFirst <= 1'b1;
            slotDelayBits <= 1'b0;
            modeSel <= 2'(mmc_pkg::MMC_MODE_UART);
        end else begin
            control <= control_next;
            coldResetOut_n <= control_next.coldResetN;
            frameSyncOut <= control_next.warmReset | frameSyncIn;
            msbFirst <= !control_next.shiftDir;
            slotDelayBits <= control_next.slotDelay;
            modeSel <= control_next.mode;
        end
    end

    mmc_dma_route routeInst (
        .mclk(mclk),
        .reset_n(reset_n),
        .dmaSelect(control_reg.dmaSelect),
        .rxFullMode(rxFullMode),
        .otherIrq(otherIrq),
        .ev(ev),
        .dmaReq2(dmaReq2),
        .dmaReq3(dmaReq3),
        .irqOwn(irqOwn),
        .irqOther(irqOther)
    );
endmodule // mmc_modem_ctrl

// File: tb/mmc_ctrl_properties.sv
// port assertions for the modem mode control block
module mmc_props (
    // watched ports
    input logic mclk,
    input logic reset_n,
    input logic otherIrq,
    input mmc_pkg::mmc_events_s ev,
    input logic rxFullMode,
    input logic frameSyncIn,
    input mmc_pkg::mmc_control_s control,
    input logic coldResetOut_n,
    input logic frameSyncOut,
    input logic msbFirst,
    input logic slotDelayBits,
    input logic [1:0] modeSel,
    input logic dmaReq2,
    input logic dmaReq3,
    input logic irqOwn,
    input logic irqOther
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic rxSrc;
    logic [1:0] sel;
    logic [1:0] req;
    // select must stand a cycle: routing lags it
    assign rxSrc = rxFullMode ? ev.rxFull : ev.rxNotEmpty;
    assign sel = control.dmaSelect;
    assign req = {dmaReq2, dmaReq3};
    a_cold_rst: assert property (coldResetOut_n == control.coldResetN)
        else $error("cold reset pin");
    a_warm_sync: assert property (control.warmReset && $stable(control) |-> frameSyncOut)
        else $error("sync not forced");
    a_sync_pass: assert property (frameSyncOut == (control.warmReset || $past(frameSyncIn)))
        else $error("sync not passed through");
    a_sel_even: assert property (!sel[0] && $stable(sel) |-> req == {$past(otherIrq), $past(ev.txRxIrq)})
        else $error("route 00");
    a_sel_one: assert property (sel == 2'h1 && $stable(sel) |-> req == {$past(rxSrc), $past(ev.txEmpty)})
        else $error("route 01");
    a_sel_three: assert property (sel == 2'h3 && $stable(sel) |-> req == {$past(ev.txRxIrq), 1'h0})
        else $error("route 11");
    a_irq_pair: assert property ({irqOwn, irqOther} == {$past(ev.txRxIrq), $past(otherIrq)})
        else $error("irq lines");
    a_slot_shift: assert property (
        {slotDelayBits, msbFirst, modeSel} == {control.slotDelay, !control.shiftDir, control.mode})
        else $error("slot or shift");
    a_reset_uart: assert property (!$past(reset_n) |-> control == 8'h00 && modeSel == 2'h0)
        else $error("reset mode");
    c_sel_one: cover property (sel == 2'h1 && dmaReq2);
    c_warm: cover property (control.warmReset && frameSyncOut);
    c_ac97: cover property (modeSel == 2'h3);
    c_sync: cover property (!control.warmReset && frameSyncOut);
endmodule // mmc_props
bind mmc_modem_ctrl mmc_props p_u (.mclk, .reset_n, .otherIrq, .ev, .rxFullMode, .frameSyncIn, .control, .coldResetOut_n,
    .frameSyncOut, .msbFirst, .slotDelayBits, .modeSel, .dmaReq2, .dmaReq3, .irqOwn, .irqOther);

// File: tb/mmc_codec_model.sv
// codec side model: frame sync source
module mmc_codec_model (
    // pins
    input logic mclk,
    input logic coldResetOut_n,
    output logic frameSyncIn = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] slot = 3'h0;
    // silent while held in cold reset
    always @(posedge mclk) begin
        slot <= coldResetOut_n ? slot + 3'h1 : 3'h0;
        frameSyncIn <= coldResetOut_n && slot == 3'h7;
    end
endmodule // mmc_codec_model

// File: tb/testbench.sv
// bench for the modem mode control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, reset_n = 1'h0, read = 1'h0, write = 1'h0, otherIrq = 1'h0, rxFullMode = 1'h0, sawFlush = 1'h0;
    logic waitrequest, frameSyncIn, coldResetOut_n, frameSyncOut, msbFirst, slotDelayBits, channelReset, fifoFlush;
    logic dmaReq2, dmaReq3, irqOwn, irqOther;
    logic [1:0] modeSel;
    logic [3:0] address = 4'h0, byteenable = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, got;
    // wanted {req2, req3, irqOwn, irqOther} per loop step, step 0 in the low nibble
    logic [63:0] routeWant = 64'h000b_000f_8c83_000f;
    mmc_pkg::mmc_events_s ev = '0;
    int mismatches = 0, samples_checked = 0;
    initial forever #25 mclk = ~mclk;
    mmc_modem_ctrl dut_u (.mclk, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .otherIrq, .ev, .rxFullMode, .frameSyncIn, .control(), .coldResetOut_n, .frameSyncOut,
        .msbFirst, .slotDelayBits, .modeSel, .channelReset, .fifoFlush, .dmaReq2, .dmaReq3, .irqOwn, .irqOther);
    mmc_codec_model codec_u (.mclk, .coldResetOut_n, .frameSyncIn);
    always @(posedge mclk) if (channelReset && fifoFlush) sawFlush <= 1'h1;
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        @(posedge mclk);
        while (waitrequest) @(posedge mclk);
        got = readdata;
        write <= 1'h0;
        read <= 1'h0;
        // let an edge pass so a following call never re-drives the strobe in this step
        @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'h1;
        @(posedge mclk);
        acc(1'h0, 4'h0, 8'h00, 4'hf);
        chk({modeSel, coldResetOut_n, got[7:0]}, 32'h0);
        // each select, then three event patterns under it
        for (int s = 0; s < 16; s++) begin
            if (s % 4 == 0) acc(1'h1, 4'h0, {2'h2, 2'(s / 4), 2'h0, 2'(s / 4)}, 4'hf);
            {otherIrq, rxFullMode, ev} <= s[0] ? 8'h54 : s[1] ? 8'h1b : 8'ha0;
            repeat (3) @(posedge mclk);
            chk({dmaReq2, dmaReq3, irqOwn, irqOther}, routeWant[4 * s +: 4]);
        end
        acc(1'h1, 4'h0, 8'h4b, 4'hf);
        repeat (2) @(posedge mclk);
        chk({coldResetOut_n, frameSyncOut, slotDelayBits, msbFirst, modeSel}, 32'h1f);
        // refused writes would otherwise drop to uart mode
        acc(1'h1, 4'h0, 8'h00, 4'h0);
        acc(1'h1, 4'h8, 8'h00, 4'hf);
        acc(1'h0, 4'h8, 8'h00, 4'hf);
        chk(got, 32'h0);
        acc(1'h0, 4'h0, 8'h00, 4'hf);
        chk(got, 32'h4b);
        acc(1'h1, 4'h0, 8'h80, 4'hf);
        repeat (3) @(posedge mclk);
        acc(1'h0, 4'h0, 8'h00, 4'hf);
        chk({sawFlush, modeSel, coldResetOut_n, got[7:0]}, 32'h800);
        stop_test;
    end
endmodule // testbench
